/* verilog/pts_top.sv */
// top level: pulse-train speed command, frequency source switch and run source
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
module pts_top
  import pts_pkg::*;
#(
  parameter int unsigned GATE = GATE_CYC
)
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic [4:0]  i_din,
  input  wire logic        i_fwd,
  input  wire logic        i_rev,
  input  wire logic        i_qa,
  input  wire logic        i_qb,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_run_fwd,
  output logic             o_run_rev,
  output logic [15:0]      o_freq_cmd,
  output logic             o_freq_neg
);
  typedef struct packed {
    pts_pins_t          s1;
    pts_pins_t          s2;
    logic               ack;
    logic [31:0]        rdata;
    logic [31:0]        fsrc1;
    logic [31:0]        fsrc2;
    logic [7:0]         pcfg;
    logic [15:0]        refrate;
    logic [15:0]        reffreq;
    logic [15:0]        topfreq;
    pts_rsel_t          runsel;
    logic [29:0]        asg;
    logic [3:0]         runcmd;
    logic [31:0]        gate;
    logic signed [19:0] cnt;
    logic signed [16:0] meas;
    logic               tick;
    logic               fwd_lat;
    logic               rev_lat;
    logic               run_fwd;
    logic               run_rev;
    logic [15:0]        fout;
    logic               fneg;
  } pts_st_t;

  pts_st_t            st_r;
  pts_st_t            st_nxt;
  logic [1:0]         a_pulse;
  logic [1:0]         a_sign;
  logic [1:0]         a_tog;
  logic [1:0]         a_hold;
  logic               c_inc;
  logic               c_dec;
  logic               req;
  logic               wr_ok;
  logic               gate_end;
  logic               hold_on;
  logic               run_act;
  logic signed [19:0] step;
  logic [19:0]        mag;
  logic [35:0]        prod;
  logic [35:0]        quo;
  logic [15:0]        q16;
  logic signed [16:0] filt;
  logic [31:0]        fsel;
  logic [31:0]        wtmp;
  logic [15:0]        fmag;
  logic               rq_f;
  logic               rq_r;
  logic               term_f;
  logic               term_r;

  // finds the input given a function code within lanes lo..hi; {assigned, level}
  function automatic logic [1:0] fn_asg(input logic [29:0] asg, input logic [5:0] code,
                                        input logic [4:0] din, input int lo, input int hi);
    logic [1:0] r;
    r = 2'b00;
    for (int i = 0; i < 5; i++)
    begin
      if (i >= lo && i <= hi && asg[6*i +: 6] == code)
      begin
        r = {1'b1, din[i]};
      end
    end
    return r;
  endfunction : fn_asg

  // byte-lane merge for a register write
  function automatic logic [31:0] fn_be(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : fn_be

  // terminal function lookup; sign may not sit on the pulse pin
  assign a_pulse = fn_asg(st_r.asg, FN_PULSE, st_r.s2.din, 4, 4);
  assign a_sign = fn_asg(st_r.asg, FN_SIGN, st_r.s2.din, 0, 3);
  assign a_tog = fn_asg(st_r.asg, FN_TOGGLE, st_r.s2.din, 0, 4);
  assign a_hold = fn_asg(st_r.asg, FN_HOLD, st_r.s2.din, 0, 4);
  assign hold_on = a_hold[1] & a_hold[0];
  assign run_act = st_r.s2.forward_run_input | st_r.s2.backward_run_input;
  assign req = i_avs_read | i_avs_write;
  assign gate_end = (st_r.gate >= GATE - 1);

  pts_pdec pts_pdec_inst (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_fmt      (pts_fmt_t'(st_r.pcfg[PC_FMT +: 2])),
    .i_enc      (st_r.pcfg[PC_ENC]),
    .i_sign_asg (a_sign[1]),
    .i_pulse    (a_pulse[1] & a_pulse[0]),
    .i_sign     (a_sign[0]),
    .i_qa       (st_r.s2.qa),
    .i_qb       (st_r.s2.qb),
    .o_inc      (c_inc),
    .o_dec      (c_dec)
  );

  pts_lpf #(.W(17)) pts_lpf_inst (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_tick (st_r.tick),
    .i_tc   (st_r.pcfg[PC_TC +: 4]),
    .i_x    (st_r.meas),
    .o_y    (filt)
  );

  // rate scaling; divide by zero reference gives zero
  always_comb
  begin
    step = c_inc ? 20'sh00001 : (c_dec ? -20'sh00001 : 20'sh00000);
    mag = st_r.cnt[19] ? 20'(-st_r.cnt) : 20'(st_r.cnt);
    prod = 36'(mag) * 36'(st_r.reffreq);
    quo = (st_r.refrate == 16'h0000) ? 36'h0 : prod / {20'h00000, st_r.refrate};
    q16 = (|quo[35:16]) ? 16'hFFFF : quo[15:0];
  end

  // frequency source choice and top clamp
  always_comb
  begin
    fsel = (a_tog[1] & a_tog[0]) ? st_r.fsrc2 : st_r.fsrc1;
    if (fsel[FS_SEL +: 5] == SEL_PULSE)
    begin
      fmag = filt[16] ? 16'(-filt) : filt[15:0];
    end
    else
    begin
      fmag = fsel[FS_SET +: 16];
    end
    if (fmag > st_r.topfreq)
    begin
      fmag = st_r.topfreq;
    end
  end

  // run request: hold latch on the terminals, then per run source, then override
  always_comb
  begin
    term_f = st_r.s2.forward_run_input | (hold_on & st_r.fwd_lat);
    term_r = st_r.s2.backward_run_input | (hold_on & st_r.rev_lat);
    case (st_r.runsel)
      RS_KEYPAD:
      begin
        rq_f = st_r.runcmd[RC_KEY] & term_f;
        rq_r = st_r.runcmd[RC_KEY] & term_r;
      end
      RS_TERM:
      begin
        rq_f = term_f;
        rq_r = term_r;
      end
      RS_KFWD:
      begin
        rq_f = st_r.runcmd[RC_KEY];
        rq_r = 1'b0;
      end
      default:
      begin
        rq_f = 1'b0;
        rq_r = st_r.runcmd[RC_KEY];
      end
    endcase
    if (st_r.runcmd[RC_OVR])
    begin
      rq_f = st_r.runcmd[RC_LFWD];
      rq_r = st_r.runcmd[RC_LREV];
    end
    if (rq_f & rq_r)
    begin
      rq_f = 1'b0;
      rq_r = 1'b0;
    end
  end

  // next state: sync, bus, rate gate, outputs
  always_comb
  begin
    st_nxt = st_r;
    wtmp = 32'h00000000;
    st_nxt.s1 = {i_qb, i_qa, i_rev, i_fwd, i_din};
    st_nxt.s2 = st_r.s1;
    // one wait cycle: answer on the second cycle of a request
    st_nxt.ack = req & ~st_r.ack;
    wr_ok = i_avs_write & st_r.ack;
    if (i_avs_read & ~st_r.ack)
    begin
      if (i_avs_address == A_FSRC1) st_nxt.rdata = st_r.fsrc1;
      else if (i_avs_address == A_FSRC2) st_nxt.rdata = st_r.fsrc2;
      else if (i_avs_address == A_PCFG) st_nxt.rdata = {24'h000000, st_r.pcfg};
      else if (i_avs_address == A_REFRATE) st_nxt.rdata = {16'h0000, st_r.refrate};
      else if (i_avs_address == A_REFFREQ) st_nxt.rdata = {16'h0000, st_r.reffreq};
      else if (i_avs_address == A_TOPFREQ) st_nxt.rdata = {16'h0000, st_r.topfreq};
      else if (i_avs_address == A_RUNSEL) st_nxt.rdata = {30'h0, st_r.runsel};
      else if (i_avs_address == A_ASSIGN) st_nxt.rdata = {2'h0, st_r.asg};
      else if (i_avs_address == A_RUNCMD) st_nxt.rdata = {28'h0, st_r.runcmd};
      else if (i_avs_address == A_STATUS)
        st_nxt.rdata = {25'h0, hold_on, st_r.rev_lat, st_r.fwd_lat, st_r.fneg,
                        a_tog[1] & a_tog[0], st_r.run_rev, st_r.run_fwd};
      else if (i_avs_address == A_FREQ) st_nxt.rdata = {15'h0, st_r.fneg, st_r.fout};
      else st_nxt.rdata = 32'h00000000;
    end
    if (wr_ok)
    begin
      if (i_avs_address == A_FSRC1)
        st_nxt.fsrc1 = fn_be(st_r.fsrc1, i_avs_writedata, i_avs_byteenable);
      else if (i_avs_address == A_FSRC2)
        st_nxt.fsrc2 = fn_be(st_r.fsrc2, i_avs_writedata, i_avs_byteenable);
      else if (i_avs_address == A_PCFG)
        st_nxt.pcfg = 8'(fn_be({24'h0, st_r.pcfg}, i_avs_writedata, i_avs_byteenable));
      else if (i_avs_address == A_REFRATE)
        st_nxt.refrate = 16'(fn_be({16'h0, st_r.refrate}, i_avs_writedata, i_avs_byteenable));
      else if (i_avs_address == A_REFFREQ)
        st_nxt.reffreq = 16'(fn_be({16'h0, st_r.reffreq}, i_avs_writedata, i_avs_byteenable));
      else if (i_avs_address == A_TOPFREQ)
      begin
        wtmp = fn_be({16'h0, st_r.topfreq}, i_avs_writedata, i_avs_byteenable);
        if (wtmp[15:0] < TOP_MIN) st_nxt.topfreq = TOP_MIN;
        else if (wtmp[15:0] > TOP_MAX) st_nxt.topfreq = TOP_MAX;
        else st_nxt.topfreq = wtmp[15:0];
      end
      else if (i_avs_address == A_RUNSEL && i_avs_byteenable[0] && !run_act)
        st_nxt.runsel = pts_rsel_t'(i_avs_writedata[1:0]);
      else if (i_avs_address == A_ASSIGN)
        st_nxt.asg = 30'(fn_be({2'h0, st_r.asg}, i_avs_writedata, i_avs_byteenable));
      else if (i_avs_address == A_RUNCMD && i_avs_byteenable[0])
        st_nxt.runcmd = i_avs_writedata[3:0];
    end
    // edge count per gate window is the rate in kp/s
    st_nxt.tick = 1'b0;
    if (gate_end)
    begin
      st_nxt.gate = 32'h00000000;
      st_nxt.cnt = step;
      st_nxt.meas = st_r.cnt[19] ? -$signed({1'b0, q16}) : $signed({1'b0, q16});
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.gate = st_r.gate + 32'h00000001;
      st_nxt.cnt = 20'(st_r.cnt + step);
    end
    // hold latch drops as soon as the hold input goes off
    st_nxt.fwd_lat = hold_on & (st_r.s2.forward_run_input | st_r.fwd_lat);
    st_nxt.rev_lat = hold_on & (st_r.s2.backward_run_input | st_r.rev_lat);
    st_nxt.fout = fmag;
    st_nxt.fneg = (fsel[FS_SEL +: 5] == SEL_PULSE) & filt[16] & (fmag != 16'h0000);
    // negative command swaps run direction; stops instead in forward-only and reverse-only sources without override
    st_nxt.run_fwd = (rq_f & ~st_r.fneg) | (rq_r & st_r.fneg);
    st_nxt.run_rev = (rq_r & ~st_r.fneg) | (rq_f & st_r.fneg);
    if (!st_r.runcmd[RC_OVR] && st_r.runsel == RS_KFWD) st_nxt.run_rev = 1'b0;
    if (!st_r.runcmd[RC_OVR] && st_r.runsel == RS_KREV) st_nxt.run_fwd = 1'b0;
  end

  // constants only under reset
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r <= '0;
      st_r.refrate <= RST_REFRATE;
      st_r.reffreq <= RST_REFFREQ;
      st_r.topfreq <= RST_TOPFREQ;
      st_r.pcfg <= RST_PCFG;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_avs_waitrequest = req & ~st_r.ack;
  assign o_avs_readdata = st_r.rdata;
  assign o_run_fwd = st_r.run_fwd;
  assign o_run_rev = st_r.run_rev;
  assign o_freq_cmd = st_r.fout;
  assign o_freq_neg = st_r.fneg;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  chk_both_stop: assert property ((!st_r.runcmd[RC_OVR] && st_r.runsel == RS_TERM &&
                  st_r.s2.forward_run_input && st_r.s2.backward_run_input) |=> !o_run_fwd && !o_run_rev)
    else $error("both run inputs did not stop");
  chk_sel_lock: assert property ((wr_ok && i_avs_address == A_RUNSEL && run_act)
                  |=> $stable(st_r.runsel))
    else $error("run source changed while running");
  chk_fwd_only: assert property ((!st_r.runcmd[RC_OVR] && st_r.runsel == RS_KFWD)
                  |=> !o_run_rev)
    else $error("reverse run in forward-only mode");
  chk_rev_only: assert property ((!st_r.runcmd[RC_OVR] && st_r.runsel == RS_KREV)
                  |=> !o_run_fwd)
    else $error("forward run in reverse-only mode");
  chk_dir_swap: assert property ((!st_r.runcmd[RC_OVR] && st_r.runsel == RS_TERM &&
                  st_r.s2.forward_run_input && !st_r.s2.backward_run_input && st_r.fneg) |=> o_run_rev && !o_run_fwd)
    else $error("negative command did not reverse");
  chk_link_over: assert property ((st_r.runcmd[RC_OVR] && st_r.runcmd[RC_LFWD] &&
                  !st_r.runcmd[RC_LREV] && !st_r.fneg) |=> o_run_fwd)
    else $error("link override ignored");
  chk_top_clamp: assert property (1'b1 |=> o_freq_cmd <= $past(st_r.topfreq))
    else $error("frequency above top frequency");
  chk_top_range: assert property (st_r.topfreq >= TOP_MIN && st_r.topfreq <= TOP_MAX)
    else $error("top frequency out of range");
  chk_zero_rate: assert property ((gate_end && st_r.cnt == 20'sh00000) |=> st_r.meas == 0)
    else $error("zero rate gave nonzero command");
  chk_fixed_pos: assert property ((fsel[FS_SEL +: 5] != SEL_PULSE) |=> !o_freq_neg)
    else $error("fixed source went negative");
  chk_hold_rel: assert property (!hold_on |=> !st_r.fwd_lat && !st_r.rev_lat)
    else $error("latch kept after hold off");
  chk_one_wait: assert property ((req && o_avs_waitrequest) |=> !o_avs_waitrequest)
    else $error("wait longer than one cycle");
  cov_run_fwd: cover property (o_run_fwd && !o_freq_neg && o_freq_cmd != 16'h0000);
  cov_run_rev_neg: cover property (o_run_rev && o_freq_neg);
  cov_hold_latch: cover property (st_r.fwd_lat && !st_r.s2.forward_run_input && o_run_fwd);
endmodule : pts_top

/* verilog/pts_pkg.sv */
// shared constants and carrier types for the pulse-train speed and run-source block
package pts_pkg;
  // timing: one rate gate of 1 ms makes the edge count read in kp/s
  localparam int unsigned CLK_MHZ  = 200;
  localparam int unsigned GATE_US  = 1000;
  localparam int unsigned GATE_CYC = GATE_US * CLK_MHZ;
  // register byte addresses
  localparam logic [5:0] A_FSRC1   = 6'h00;
  localparam logic [5:0] A_FSRC2   = 6'h04;
  localparam logic [5:0] A_PCFG    = 6'h08;
  localparam logic [5:0] A_REFRATE = 6'h0C;
  localparam logic [5:0] A_REFFREQ = 6'h10;
  localparam logic [5:0] A_TOPFREQ = 6'h14;
  localparam logic [5:0] A_RUNSEL  = 6'h18;
  localparam logic [5:0] A_ASSIGN  = 6'h1C;
  localparam logic [5:0] A_RUNCMD  = 6'h20;
  localparam logic [5:0] A_STATUS  = 6'h24;
  localparam logic [5:0] A_FREQ    = 6'h28;
  // field positions
  localparam int unsigned PC_FMT  = 0;
  localparam int unsigned PC_ENC  = 2;
  localparam int unsigned PC_TC   = 4;
  localparam int unsigned FS_SEL  = 0;
  localparam int unsigned FS_SET  = 16;
  localparam int unsigned RC_KEY  = 0;
  localparam int unsigned RC_OVR  = 1;
  localparam int unsigned RC_LFWD = 2;
  localparam int unsigned RC_LREV = 3;
  // source selector and input function codes
  localparam logic [4:0] SEL_PULSE = 5'h0C;
  localparam logic [5:0] FN_HOLD   = 6'h06;
  localparam logic [5:0] FN_TOGGLE = 6'h0B;
  localparam logic [5:0] FN_PULSE  = 6'h30;
  localparam logic [5:0] FN_SIGN   = 6'h31;
  // reset values and top-frequency range, frequencies in 0.1 Hz
  localparam logic [15:0] RST_REFRATE = 16'h000A;
  localparam logic [15:0] RST_REFFREQ = 16'h0258;
  localparam logic [15:0] RST_TOPFREQ = 16'h0258;
  localparam logic [15:0] TOP_MIN     = 16'h00FA;
  localparam logic [15:0] TOP_MAX     = 16'h1388;
  localparam logic [7:0]  RST_PCFG    = 8'h20;
  typedef enum logic [1:0] {FMT_SIGN = 2'b00, FMT_SEP = 2'b01, FMT_QB = 2'b10,
                            FMT_QA = 2'b11} pts_fmt_t;
  typedef enum logic [1:0] {RS_KEYPAD = 2'b00, RS_TERM = 2'b01, RS_KFWD = 2'b10,
                            RS_KREV = 2'b11} pts_rsel_t;
  // terminal pins as one carrier
  typedef struct packed {
    logic       qb;
    logic       qa;
    logic       backward_run_input;
    logic       forward_run_input;
    logic [4:0] din;
  } pts_pins_t;
endpackage : pts_pkg

/* verilog/pts_pdec.sv */
// pulse format decoder: turns synced pulse pins into signed count strobes
`timescale 1ns/100ps
module pts_pdec
  import pts_pkg::*;
(
  input  wire logic     i_mclk,
  input  wire logic     i_rst,
  input  wire pts_fmt_t i_fmt,
  input  wire logic     i_enc,
  input  wire logic     i_sign_asg,
  input  wire logic     i_pulse,
  input  wire logic     i_sign,
  input  wire logic     i_qa,
  input  wire logic     i_qb,
  output logic          o_inc,
  output logic          o_dec
);
  typedef struct packed {
    logic p;
    logic a;
    logic b;
    logic inc;
    logic dec;
  } pts_pdec_st_t;
  pts_pdec_st_t st_r;
  pts_pdec_st_t st_nxt;
  pts_fmt_t     fmt;
  logic         qedge;
  logic         qpos;

  // edge detect and format decode; in the quadrature formats every single-phase edge of either phase counts
  always_comb
  begin
    fmt = i_enc ? i_fmt : FMT_SIGN;
    qedge = (st_r.a ^ i_qa) ^ (st_r.b ^ i_qb);
    qpos = st_r.a ^ i_qb;  // high when phase second leads
    st_nxt = st_r;
    st_nxt.p = i_pulse;
    st_nxt.a = i_qa;
    st_nxt.b = i_qb;
    st_nxt.inc = 1'b0;
    st_nxt.dec = 1'b0;
    case (fmt)
      FMT_SIGN:
      begin
        st_nxt.inc = i_pulse & ~st_r.p & ~(i_sign_asg & i_sign);
        st_nxt.dec = i_pulse & ~st_r.p & i_sign_asg & i_sign;
      end
      FMT_SEP:
      begin
        st_nxt.inc = i_qa & ~st_r.a & ~(i_qb & ~st_r.b);
        st_nxt.dec = i_qb & ~st_r.b & ~(i_qa & ~st_r.a);
      end
      FMT_QB:
      begin
        st_nxt.inc = qedge & qpos;
        st_nxt.dec = qedge & ~qpos;
      end
      default:
      begin
        st_nxt.inc = qedge & ~qpos;
        st_nxt.dec = qedge & qpos;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_inc = st_r.inc;
  assign o_dec = st_r.dec;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  chk_sign_absent: assert property ((fmt == FMT_SIGN && !i_sign_asg) |=> !o_dec)
    else $error("negative count with no sign input");
  chk_quad_blead: assert property ((fmt == FMT_QB && qedge && qpos) |=> o_inc && !o_dec)
    else $error("b-lead edge not counted up");
  chk_quad_alead: assert property ((fmt == FMT_QA && qedge && qpos) |=> o_dec && !o_inc)
    else $error("a-lead code did not invert");
  chk_no_card: assert property ((!i_enc && !(i_pulse && !st_r.p)) |=> !o_inc && !o_dec)
    else $error("count without card from other pin");
  cov_quad_count: cover property (fmt == FMT_QB && qedge && qpos ##1 o_inc);
endmodule : pts_pdec

/* verilog/pts_lpf.sv */
// first-order smoothing of the pulse-derived frequency command
`timescale 1ns/100ps
module pts_lpf #(
  parameter int W = 17
)
(
  input  wire logic                i_mclk,
  input  wire logic                i_rst,
  input  wire logic                i_tick,
  input  wire logic [3:0]          i_tc,
  input  wire logic signed [W-1:0] i_x,
  output logic signed [W-1:0]      o_y
);
  typedef struct packed {
    logic signed [W+15:0] acc;
  } pts_lpf_st_t;
  pts_lpf_st_t          st_r;
  pts_lpf_st_t          st_nxt;
  logic signed [W+16:0] diff;

  // y += (x - y) / 2^tc once per gate; larger tc is slower
  always_comb
  begin
    diff = $signed({i_x[W-1], i_x, 16'h0000}) - $signed({st_r.acc[W+15], st_r.acc});
    st_nxt = st_r;
    if (i_tick)
    begin
      st_nxt.acc = (W+16)'(st_r.acc + (diff >>> i_tc));
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_y = st_r.acc[W+15:16];

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  chk_tc_zero: assert property ((i_tick && i_tc == 4'h0) |=> o_y == $past(i_x))
    else $error("zero time constant did not pass input");
  chk_idle_hold: assert property (!i_tick |=> $stable(o_y))
    else $error("filter moved without a gate tick");
endmodule : pts_lpf

/* sim/pts_pulse_src.sv */
// model of the external pulse generator wired to the drive terminals
`timescale 1ns/100ps
module pts_pulse_src
(
  input  wire logic       i_mclk,
  input  wire logic [2:0] i_mode,
  output logic            o_pin5,
  output logic            o_qa,
  output logic            o_qb
);
  logic [5:0] cnt_r;
  logic [1:0] ph;
  logic       q1;
  // 40-cycle frame in 10-cycle quarters, far above the 2-cycle minimum width
  assign ph = cnt_r < 6'h0A ? 2'h0 : cnt_r < 6'h14 ? 2'h1 : cnt_r < 6'h1E ? 2'h2 : 2'h3;
  assign q1 = ph[1] ^ ph[0];
  // lines start low so the synchronisers never see an unknown
  initial
  begin
    cnt_r  = 6'h00;
    o_pin5 = 1'b0;
    o_qa   = 1'b0;
    o_qb   = 1'b0;
  end
  // modes: 1 fifth input, 2 first phase, 3 second phase, 4 first leads, 5 second leads
  always @(posedge i_mclk)
  begin
    cnt_r  <= (cnt_r == 6'h27) ? 6'h00 : cnt_r + 6'h01;
    o_pin5 <= (i_mode == 3'h1) & ~ph[0];
    o_qa   <= (i_mode == 3'h2) ? ~ph[0] : (i_mode == 3'h4) ? q1 : (i_mode == 3'h5) & ph[1];
    o_qb   <= (i_mode == 3'h3) ? ~ph[0] : (i_mode == 3'h5) ? q1 : (i_mode == 3'h4) & ph[1];
  end
endmodule : pts_pulse_src

/* sim/tb_pulse_train_speed_and_run_source.sv */
// self-checking bench for the pulse-train speed and run-source block
`timescale 1ns/100ps
module tb_pulse_train_speed_and_run_source
  import pts_pkg::*;
;
  localparam int unsigned GT = 200;
  localparam logic [2:0] MD [8] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h5, 3'h4, 3'h4, 3'h4};
  localparam logic [7:0] PC [8] = '{8'h00, 8'h00, 8'h05, 8'h05, 8'h06, 8'h06, 8'h07, 8'h03};
  localparam logic [7:0] NG = 8'h2A;
  logic        i_mclk = 1'b0;
  logic        i_rst  = 1'b1;
  logic        sgn = 1'b0, tog = 1'b0, three_wire_latch_input = 1'b0, forward_run_input = 1'b0, backward_run_input = 1'b0;
  logic        rd = 1'b0, wr = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [2:0]  mode = 3'h0;
  logic [31:0] q, rdat;
  logic        pin5, qa, qb, run_f, run_r, neg, wq;
  logic [15:0] fc;
  int          num_errors = 0;
  int          tests_run = 0;

  initial forever #2.5 i_mclk = ~i_mclk;

  pts_top #(.GATE(GT)) pts_top_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_din({pin5, 1'b0, three_wire_latch_input, tog, sgn}),
    .i_fwd(forward_run_input), .i_rev(backward_run_input), .i_qa(qa), .i_qb(qb), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .o_run_fwd(run_f), .o_run_rev(run_r),
    .o_freq_cmd(fc), .o_freq_neg(neg));

  pts_pulse_src pts_pulse_src_inst (.i_mclk(i_mclk), .i_mode(mode), .o_pin5(pin5),
    .o_qa(qa), .o_qb(qb));

  task automatic results();
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // one bus cycle; waitrequest is judged at each rising edge, release only after the answer
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    rd   <= ~w;
    wr   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge i_mclk);
      n++;
    end while (wq !== 1'b0 && n < 40);
    if (n >= 40)
    begin
      num_errors++;
      results();
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : cyc

  // one pulse format case, left settled for three gates
  task automatic fmt(input int i);
    mode <= MD[i];
    sgn  <= NG[i] & (MD[i] == 3'h1);
    bus(1'b1, A_PCFG, {24'h0, PC[i]});
    bus(1'b1, A_REFRATE, PC[i][1] ? 32'h14 : 32'h0A);
    cyc(3 * GT);
  endtask : fmt

  initial
  begin
    cyc(12);
    i_rst <= 1'b0;
    bus(1'b0, A_PCFG, 32'h0);
    chk(q, 32'h20);
    bus(1'b0, A_REFRATE, 32'h0);
    chk(q, 32'h0A);
    bus(1'b0, A_TOPFREQ, 32'h0);
    chk(q, 32'h258);
    bus(1'b0, 6'h2C, 32'h0);
    chk(q, 32'h0);
    // run terminals stay low while functions are reassigned
    bus(1'b1, A_ASSIGN, 32'h300062F1);
    bus(1'b1, A_FSRC1, 32'h0C);
    bus(1'b1, A_RUNSEL, 32'h1);
    forward_run_input <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      fmt(i);
      chk({15'h0, neg, fc}, PC[i] == 8'h03 ? 32'h0 : {15'h0, NG[i], 16'h0258});
      if (PC[i] != 8'h03)
        chk({30'h0, run_r, run_f}, NG[i] ? 32'h2 : 32'h1);
    end
    fmt(0);
    bus(1'b1, A_RUNSEL, 32'h2);
    bus(1'b0, A_RUNSEL, 32'h0);
    chk(q, 32'h1);
    backward_run_input <= 1'b1;
    cyc(6);
    chk({30'h0, run_r, run_f}, 32'h0);
    backward_run_input <= 1'b0;
    forward_run_input <= 1'b0;
    three_wire_latch_input <= 1'b1;
    cyc(6);
    forward_run_input <= 1'b1;
    cyc(4);
    forward_run_input <= 1'b0;
    cyc(6);
    chk({30'h0, run_r, run_f}, 32'h1);
    three_wire_latch_input <= 1'b0;
    cyc(6);
    chk({30'h0, run_r, run_f}, 32'h0);
    bus(1'b1, A_RUNCMD, 32'h1);
    backward_run_input <= 1'b1;
    cyc(6);
    chk({30'h0, run_r, run_f}, 32'h2);
    backward_run_input <= 1'b0;
    cyc(6);
    bus(1'b1, A_RUNSEL, 32'h3);
    cyc(6);
    chk({30'h0, run_r, run_f}, 32'h2);
    sgn <= 1'b1;
    cyc(3 * GT);
    chk({30'h0, run_r, run_f}, 32'h0);
    sgn <= 1'b0;
    cyc(3 * GT);
    bus(1'b1, A_RUNCMD, 32'h6);
    cyc(6);
    chk({30'h0, run_r, run_f}, 32'h1);
    bus(1'b1, A_FSRC2, 32'h012C0000);
    tog <= 1'b1;
    cyc(3 * GT);
    bus(1'b0, A_FREQ, 32'h0);
    chk(q, 32'h12C);
    bus(1'b1, A_TOPFREQ, 32'h10);
    bus(1'b0, A_TOPFREQ, 32'h0);
    chk(q, 32'hFA);
    tog <= 1'b0;
    cyc(3 * GT);
    chk({16'h0, fc}, 32'hFA);
    bus(1'b1, A_TOPFREQ, 32'hFFFF);
    bus(1'b0, A_TOPFREQ, 32'h0);
    chk(q, 32'h1388);
    // pulses stop: a slow filter still shows a value three gates on, then decays to zero
    mode <= 3'h0;
    bus(1'b1, A_PCFG, 32'h20);
    cyc(3 * GT);
    chk({31'h0, fc != 16'h0000}, 32'h1);
    cyc(60 * GT);
    chk({15'h0, neg, fc}, 32'h0);
    results();
  end
endmodule : tb_pulse_train_speed_and_run_source
